// ### core/lom_config_regs.sv
// LED switch override, group membership and general fault mask registers.
// Assumes a serial engine issuing one-cycle read and write strobes, a PWM
// engine giving per-switch close requests and detectors giving fault levels.
//
// What this block does
// - Set override bit keeps its bypass switch closed whatever the duty settings.
// - Group A members take group writes with code 0001 and group A duty writes.
// - Group B members take group writes with code 0010 and group B duty writes.
// - On thermal shutdown, action bit clear closes all switches, set opens all.
// - Lamp_open_fault mask set keeps lamp_open_fault detections off the fault output.
// - Pump-not-ready mask set keeps that condition off the fault output.
// - Resistor-decode mask set keeps decode errors off the fault output.
// - Mask bits and shutdown action bit are read/write and reset to zero.
// - Fault output asserts while any flag is high and its mask is clear.
// - Open and short faults count only while the switch is open.
`timescale 1ns/1ns
`default_nettype none
module lom_config_regs
  import lom_pkg::*;
(
  input wire logic core_clk, // System clock, 125 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic regWrEn, // One-cycle register write strobe.
  input wire logic regRdEn, // One-cycle register read strobe.
  input wire logic [ADDR_WIDTH-1:0] regAddr, // Register offset.
  input wire logic [REG_WIDTH-1:0] regWrData, // Write data.
  output logic [REG_WIDTH-1:0] regRdData, // Read data, held until next read.
  output logic regRdValid, // Pulse one cycle after a read strobe.
  input wire logic [NUM_SWITCHES-1:0] dutyClose, // PWM engine close request.
  input wire logic thermalShutdown, // Thermal shutdown level.
  output logic [NUM_SWITCHES-1:0] switchClosed, // Final switch drive, 1 is closed.
  input wire logic [GROUP_CODE_WIDTH-1:0] groupCode, // Code of a group write.
  input wire logic groupSoftStartWr, // Write to group_soft_start_reg.
  input wire logic groupDimPeriodWr, // Write to group_dim_period_reg.
  input wire logic firstGroupDutyWr, // Write to first_group_duty_reg.
  input wire logic secondGroupDutyWr, // Write to second_group_duty_reg.
  output logic [NUM_SWITCHES-1:0] groupTargets, // Switches that take the group write.
  output logic groupTargetsValid, // Pulse marking groupTargets.
  input wire logic serialError, // Serial error flag.
  input wire logic [NUM_SWITCHES-1:0] lampOpenFault, // Open detections per switch.
  input wire logic [NUM_SWITCHES-1:0] lampShortFault, // Short detections per switch.
  input wire logic pumpNotReady, // Charge pump not ready flag.
  input wire logic resistorDecodeError, // Resistor decode error flag.
  input wire logic overtempWarning, // Thermal warning flag.
  output logic faultOutput, // Fault level, active high.
  output logic faultOutputN, // Open-drain pin value, always low.
  output logic faultOutputOeN, // Pin enable, low while pulling down.
  input wire logic faultOutputIn // Pin level as seen on the wire.
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic hitReg(input logic [ADDR_WIDTH-1:0] addr,
                                  input logic [7:0] ofs);
    hitReg = (addr == ofs);
  endfunction : hitReg

  function automatic logic [NUM_FLAGS-1:0] maskVector(input logic [12:0] m);
    logic [NUM_FLAGS-1:0] v;
    v = '0;
    v[FLG_WARN] = m[POS_WARN_MASK];
    v[FLG_DECODE] = m[POS_DECODE_MASK];
    v[FLG_PUMP] = m[POS_PUMP_MASK];
    v[FLG_SHORT] = m[POS_SHORT_MASK];
    v[FLG_OPEN] = m[POS_OPEN_MASK];
    v[FLG_SERIAL] = m[POS_SERIAL_MASK];
    maskVector = v;
  endfunction : maskVector

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [NUM_SWITCHES-1:0] forceClosedBits_reg;
  logic [NUM_SWITCHES-1:0] firstGroupMembers_reg;
  logic [NUM_SWITCHES-1:0] secondGroupMembers_reg;
  logic [12:0] faultMask_reg;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      forceClosedBits_reg <= RST_SWITCH_BITS;
      firstGroupMembers_reg <= RST_SWITCH_BITS;
      secondGroupMembers_reg <= RST_SWITCH_BITS;
      faultMask_reg <= RST_FAULT_MASK;
    end
    else if (regWrEn)
    begin
      if (hitReg(regAddr, OFS_FORCE_CLOSED))
        forceClosedBits_reg <= regWrData[NUM_SWITCHES-1:0];
      if (hitReg(regAddr, OFS_GROUP_A))
        firstGroupMembers_reg <= regWrData[NUM_SWITCHES-1:0];
      if (hitReg(regAddr, OFS_GROUP_B))
        secondGroupMembers_reg <= regWrData[NUM_SWITCHES-1:0];
      if (hitReg(regAddr, OFS_FAULT_MASK))
        faultMask_reg <= regWrData & FAULT_MASK_WRITABLE;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [REG_WIDTH-1:0] rdData_next;

  always_comb
  begin
    rdData_next = '0;
    if (hitReg(regAddr, OFS_FORCE_CLOSED))
      rdData_next = {1'b0, forceClosedBits_reg};
    else if (hitReg(regAddr, OFS_GROUP_A))
      rdData_next = {1'b0, firstGroupMembers_reg};
    else if (hitReg(regAddr, OFS_GROUP_B))
      rdData_next = {1'b0, secondGroupMembers_reg};
    else if (hitReg(regAddr, OFS_FAULT_MASK))
      rdData_next = faultMask_reg;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdData <= '0;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRdEn;
      if (regRdEn)
        regRdData <= rdData_next;
    end
  end

  // ----------------------------------------------------------------------
  // Switch drive
  // ----------------------------------------------------------------------
  // Shutdown outranks the override so that an overheated part really
  // reaches the chosen safe state, even for a switch held closed.
  logic [NUM_SWITCHES-1:0] switchClosed_next;

  genvar sw;
  generate
    for (sw = 0; sw < NUM_SWITCHES; sw++)
    begin : g_switch
      always_comb
      begin
        if (thermalShutdown)
          switchClosed_next[sw] = ~faultMask_reg[POS_SHDN_ACTION];
        else if (forceClosedBits_reg[sw])
          switchClosed_next[sw] = 1'b1;
        else
          switchClosed_next[sw] = dutyClose[sw];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      switchClosed <= '0;
    else
      switchClosed <= switchClosed_next;
  end

  // ----------------------------------------------------------------------
  // Group write qualification
  // ----------------------------------------------------------------------
  logic groupCodedWr;
  logic takeFirst;
  logic takeSecond;

  assign groupCodedWr = groupSoftStartWr | groupDimPeriodWr;
  assign takeFirst = (groupCodedWr && groupCode == GROUP_CODE_A) || firstGroupDutyWr;
  assign takeSecond = (groupCodedWr && groupCode == GROUP_CODE_B) || secondGroupDutyWr;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      groupTargets <= '0;
      groupTargetsValid <= 1'b0;
    end
    else
    begin
      groupTargetsValid <= takeFirst | takeSecond;
      groupTargets <= ({NUM_SWITCHES{takeFirst}} & firstGroupMembers_reg)
        | ({NUM_SWITCHES{takeSecond}} & secondGroupMembers_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Fault flags and gate
  // ----------------------------------------------------------------------
  // Detections are qualified by the registered switch drive, which is the
  // state the switch actually holds; a closed switch cannot see an LED.
  lom_fault_if faultBus ();
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] masks_reg;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_reg <= '0;
      masks_reg <= '0;
    end
    else
    begin
      flags_reg[FLG_WARN] <= overtempWarning;
      flags_reg[FLG_DECODE] <= resistorDecodeError;
      flags_reg[FLG_PUMP] <= pumpNotReady;
      flags_reg[FLG_SHORT] <= |(lampShortFault & ~switchClosed);
      flags_reg[FLG_OPEN] <= |(lampOpenFault & ~switchClosed);
      flags_reg[FLG_SERIAL] <= serialError;
      masks_reg <= maskVector(faultMask_reg);
    end
  end

  assign faultBus.flags = flags_reg;
  assign faultBus.masks = masks_reg;

  lom_fault_gate u_gate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .faultBus(faultBus)
  );

  assign faultOutput = faultBus.faultActive;
  assign faultOutputOeN = faultBus.faultPinOeN;
  assign faultOutputN = 1'b0;

  // The wire level is not used by this block; the pin is output only.
  logic unusedPin;
  assign unusedPin = faultOutputIn;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  override_holds_closed_a: assert property (
    (!$past(thermalShutdown) && $past(forceClosedBits_reg[0])) |-> switchClosed[0])
    else $error("override bit did not close its switch");
  group_a_select_a: assert property (
    (groupSoftStartWr && groupCode == GROUP_CODE_A && !secondGroupDutyWr)
      |=> groupTargetsValid && groupTargets == $past(firstGroupMembers_reg))
    else $error("group A write did not reach group A members");
  group_b_select_a: assert property (
    (groupDimPeriodWr && groupCode == GROUP_CODE_B && !firstGroupDutyWr)
      |=> groupTargetsValid && groupTargets == $past(secondGroupMembers_reg))
    else $error("group B write did not reach group B members");
  shutdown_action_a: assert property (
    thermalShutdown |=> switchClosed == {NUM_SWITCHES{!$past(faultMask_reg[POS_SHDN_ACTION])}})
    else $error("shutdown did not apply the selected switch action");
  open_mask_blocks_a: assert property (
    (faultMask_reg == 13'h0010 && (|lampOpenFault)
      && !overtempWarning && !resistorDecodeError && !pumpNotReady
      && !serialError && !(|lampShortFault))[*3] |=> !faultOutput)
    else $error("masked open detection reached the fault output");
  pump_flag_asserts_a: assert property (
    (!faultMask_reg[POS_PUMP_MASK] && pumpNotReady)[*3] |=> faultOutput)
    else $error("unmasked pump not ready did not assert fault");
  decode_flag_asserts_a: assert property (
    (!faultMask_reg[POS_DECODE_MASK] && resistorDecodeError)[*3] |=> faultOutput)
    else $error("unmasked decode error did not assert fault");
  warn_flag_asserts_a: assert property (
    (!faultMask_reg[POS_WARN_MASK] && overtempWarning)[*3] |=> faultOutput)
    else $error("unmasked thermal warning did not assert fault");
  mask_write_back_a: assert property (
    (regWrEn && hitReg(regAddr, OFS_FAULT_MASK))
      |=> faultMask_reg == ($past(regWrData) & FAULT_MASK_WRITABLE))
    else $error("fault mask write not stored");
  serial_flag_asserts_a: assert property (
    (!faultMask_reg[POS_SERIAL_MASK] && serialError)[*3] |=> faultOutput)
    else $error("unmasked serial error did not assert fault");
  closed_hides_open_a: assert property (
    (|(lampOpenFault & switchClosed) && !(|(lampOpenFault & ~switchClosed)))
      |=> !flags_reg[FLG_OPEN])
    else $error("open fault counted on a closed switch");
  closed_hides_short_a: assert property (
    (|(lampShortFault & switchClosed) && !(|(lampShortFault & ~switchClosed)))
      |=> !flags_reg[FLG_SHORT])
    else $error("short fault counted on a closed switch");
  open_flag_asserts_a: assert property (
    (!faultMask_reg[POS_OPEN_MASK] && |(lampOpenFault & ~switchClosed))[*3] |=> faultOutput)
    else $error("unmasked open detection did not assert fault");
  short_flag_asserts_a: assert property (
    (!faultMask_reg[POS_SHORT_MASK] && |(lampShortFault & ~switchClosed))[*3] |=> faultOutput)
    else $error("unmasked short detection did not assert fault");
  short_mask_blocks_a: assert property (
    (faultMask_reg == 13'h0008 && (|lampShortFault)
      && !overtempWarning && !resistorDecodeError && !pumpNotReady
      && !serialError && !(|lampOpenFault))[*3] |=> !faultOutput)
    else $error("masked short detection reached the fault output");
  no_flag_quiet_a: assert property (
    (!overtempWarning && !resistorDecodeError && !pumpNotReady && !serialError
      && !(|lampOpenFault) && !(|lampShortFault))[*3] |=> !faultOutput)
    else $error("fault output high with no flag raised");
  mask_read_back_a: assert property (
    (regRdEn && hitReg(regAddr, OFS_FAULT_MASK))
      |=> regRdValid && regRdData == $past(faultMask_reg))
    else $error("fault mask read returned a wrong value");

endmodule : lom_config_regs
`default_nettype wire

// ### core/lom_fault_gate.sv
// Fault output gate: combines qualified fault flags with their masks.
// Assumes flags and masks are stable flip-flop outputs on core_clk.
`timescale 1ns/1ns
`default_nettype none
module lom_fault_gate
  import lom_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  lom_fault_if.gate faultBus // Flags in, fault level out.
);

  logic faultNext;

  // ----------------------------------------------------------------------
  // Fault decision
  // ----------------------------------------------------------------------
  assign faultNext = |(faultBus.flags & ~faultBus.masks);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      faultBus.faultActive <= 1'b0;
      faultBus.faultPinOeN <= 1'b1;
    end
    else
    begin
      faultBus.faultActive <= faultNext;
      faultBus.faultPinOeN <= ~faultNext;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  gate_follows_flags_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    faultBus.faultActive == $past(|(faultBus.flags & ~faultBus.masks)))
    else $error("fault level does not follow unmasked flags");
  pin_matches_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    faultBus.faultPinOeN == !faultBus.faultActive)
    else $error("fault pin enable disagrees with fault level");

endmodule : lom_fault_gate
`default_nettype wire

// ### include/lom_fault_if.sv
// Carrier between the register core and the fault output gate.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
`default_nettype none
interface lom_fault_if;
  import lom_pkg::*;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] masks;
  logic faultActive;
  logic faultPinOeN;

  modport core (output flags, output masks, input faultActive, input faultPinOeN);
  modport gate (input flags, input masks, output faultActive, output faultPinOeN);
endinterface : lom_fault_if
`default_nettype wire

// ### include/lom_pkg.sv
// Constants shared by the LED override, group and fault mask block.
// Assumes a 13-bit register word as used by the serial register engine.
package lom_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_SWITCHES = 12;
  localparam int unsigned REG_WIDTH = 13;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned NUM_FLAGS = 6;
  localparam int unsigned GROUP_CODE_WIDTH = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_FORCE_CLOSED = 8'h09;
  localparam logic [7:0] OFS_GROUP_A = 8'h0a;
  localparam logic [7:0] OFS_GROUP_B = 8'h0b;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h0c;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [11:0] RST_SWITCH_BITS = 12'h000;
  localparam logic [12:0] RST_FAULT_MASK = 13'h0000;

  // ----------------------------------------------------------------------
  // General fault mask field positions
  // ----------------------------------------------------------------------
  localparam int unsigned POS_WARN_MASK = 0;
  localparam int unsigned POS_DECODE_MASK = 1;
  localparam int unsigned POS_PUMP_MASK = 2;
  localparam int unsigned POS_SHORT_MASK = 3;
  localparam int unsigned POS_OPEN_MASK = 4;
  localparam int unsigned POS_SERIAL_MASK = 6;
  localparam int unsigned POS_SHDN_ACTION = 12;
  localparam logic [12:0] FAULT_MASK_WRITABLE = 13'h105f;

  // ----------------------------------------------------------------------
  // Fault flag vector positions, shared by the mask vector
  // ----------------------------------------------------------------------
  localparam int unsigned FLG_WARN = 0;
  localparam int unsigned FLG_DECODE = 1;
  localparam int unsigned FLG_PUMP = 2;
  localparam int unsigned FLG_SHORT = 3;
  localparam int unsigned FLG_OPEN = 4;
  localparam int unsigned FLG_SERIAL = 5;

  // ----------------------------------------------------------------------
  // Group codes carried by group soft-start and dimming-period writes
  // ----------------------------------------------------------------------
  localparam logic [3:0] GROUP_CODE_A = 4'h1;
  localparam logic [3:0] GROUP_CODE_B = 4'h2;

endpackage : lom_pkg

// ### verification/lom_config_regs_tb_top.sv
// Self-checking bench for the override, group and fault mask registers.
// Assumes lom_host_model drives the register strobes.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module lom_config_regs_tb_top;
  import lom_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrEn, regRdEn, regRdValid, thermalShutdown, groupTargetsValid;
  logic [7:0] regAddr;
  logic [12:0] regWrData, regRdData, rd;
  logic [11:0] dutyClose = 12'h000, switchClosed, groupTargets;
  logic [11:0] lampOpenFault = 12'h000, lampShortFault = 12'h000;
  logic [3:0] groupCode = 4'h0;
  logic groupSoftStartWr = 1'b0, groupDimPeriodWr = 1'b0;
  logic firstGroupDutyWr = 1'b0, secondGroupDutyWr = 1'b0;
  logic serialError = 1'b0, pumpNotReady = 1'b0, resistorDecodeError = 1'b0;
  logic overtempWarning = 1'b0, faultOutput, faultOutputN, faultOutputOeN;
  wire logic faultOutputIn;
  int fails = 0;
  int checksDone = 0;

  // Open-drain wire with a pull-up.
  assign faultOutputIn = faultOutputOeN ? 1'b1 : faultOutputN;
  initial thermalShutdown = 1'b0;
  initial forever #4 core_clk = ~core_clk;

  lom_host_model host_u (.core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

  lom_config_regs dut_u (.core_clk(core_clk), .reset_n(reset_n), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .dutyClose(dutyClose), .thermalShutdown(thermalShutdown),
    .switchClosed(switchClosed), .groupCode(groupCode), .groupSoftStartWr(groupSoftStartWr),
    .groupDimPeriodWr(groupDimPeriodWr), .firstGroupDutyWr(firstGroupDutyWr),
    .secondGroupDutyWr(secondGroupDutyWr), .groupTargets(groupTargets),
    .groupTargetsValid(groupTargetsValid), .serialError(serialError),
    .lampOpenFault(lampOpenFault), .lampShortFault(lampShortFault),
    .pumpNotReady(pumpNotReady), .resistorDecodeError(resistorDecodeError),
    .overtempWarning(overtempWarning), .faultOutput(faultOutput),
    .faultOutputN(faultOutputN), .faultOutputOeN(faultOutputOeN),
    .faultOutputIn(faultOutputIn));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task summarize();
    $display("checks=%0d errors=%0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic readChk(input logic [7:0] ofs, input logic [12:0] exp);
    logic ok;
    host_u.readReg(ofs, rd, ok);
    if (!ok)
    begin
      fails++;
      summarize();
    end
    `CHK(rd, exp)
  endtask : readChk

  // Waits a bounded time for switchClosed (sel 1) or faultOutput (sel 0).
  task automatic waitOut(input bit sel, input logic [11:0] exp);
    int n;
    for (n = 0; n < 8; n++)
    begin
      @(posedge core_clk);
      #1;
      if ((sel ? switchClosed : {11'h000, faultOutput}) === exp)
        return;
    end
    fails++;
    summarize();
  endtask : waitOut

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic testRegs();
    readChk(OFS_FORCE_CLOSED, 13'h0000);
    readChk(OFS_GROUP_A, 13'h0000);
    readChk(OFS_GROUP_B, 13'h0000);
    readChk(OFS_FAULT_MASK, 13'h0000);
    host_u.writeReg(OFS_FAULT_MASK, 13'h1fff);
    readChk(OFS_FAULT_MASK, 13'h105f);
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    readChk(OFS_FAULT_MASK, 13'h0000);
    host_u.writeReg(8'h05, 13'h1fff);
    readChk(8'h05, 13'h0000);
    host_u.writeReg(OFS_FAULT_MASK, 13'h0000);
    readChk(OFS_FAULT_MASK, 13'h0000);
  endtask : testRegs

  task automatic testOverride();
    host_u.writeReg(OFS_FORCE_CLOSED, 13'h10a5);
    readChk(OFS_FORCE_CLOSED, 13'h00a5);
    waitOut(1'b1, 12'h0a5);
    dutyClose = 12'hf00;
    waitOut(1'b1, 12'hfa5);
    `CHK(switchClosed, 12'hfa5)
    lampOpenFault = 12'h0a5;
    lampShortFault = 12'h0a5;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(faultOutput, 1'b0)
    lampOpenFault = 12'h002;
    waitOut(1'b0, 12'h001);
    `CHK(faultOutputIn, 1'b0)
    lampOpenFault = 12'h000;
    lampShortFault = 12'h000;
    host_u.writeReg(OFS_FORCE_CLOSED, 13'h0000);
    dutyClose = 12'h00f;
    thermalShutdown = 1'b1;
    waitOut(1'b1, 12'hfff);
    `CHK(switchClosed, 12'hfff)
    host_u.writeReg(OFS_FAULT_MASK, 13'h1000);
    waitOut(1'b1, 12'h000);
    `CHK(switchClosed, 12'h000)
    thermalShutdown = 1'b0;
    waitOut(1'b1, 12'h00f);
    host_u.writeReg(OFS_FAULT_MASK, 13'h0000);
    waitOut(1'b0, 12'h000);
    dutyClose = 12'h000;
  endtask : testOverride

  task automatic testGroups();
    int strobe[9] = '{0, 0, 1, 1, 2, 3, 4, 0, 1};
    logic [3:0] code[9] = '{4'h1, 4'h2, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h3, 4'h0};
    logic [11:0] tgt[9] = '{12'h00f, 12'h0f0, 12'h00f, 12'h0f0, 12'h00f, 12'h0f0, 12'h0ff,
      12'h000, 12'h000};
    logic seen;
    logic [11:0] got;
    host_u.writeReg(OFS_GROUP_A, 13'h100f);
    host_u.writeReg(OFS_GROUP_B, 13'h00f0);
    readChk(OFS_GROUP_B, 13'h00f0);
    for (int k = 0; k < 9; k++)
    begin
      @(posedge core_clk);
      #1;
      groupCode = code[k];
      groupSoftStartWr = (strobe[k] == 0);
      groupDimPeriodWr = (strobe[k] == 1);
      firstGroupDutyWr = (strobe[k] == 2 || strobe[k] == 4);
      secondGroupDutyWr = (strobe[k] == 3 || strobe[k] == 4);
      @(posedge core_clk);
      #1;
      {groupSoftStartWr, groupDimPeriodWr, firstGroupDutyWr, secondGroupDutyWr} = 4'h0;
      seen = 1'b0;
      got = 12'h000;
      for (int n = 0; n < 3 && !seen; n++)
      begin
        if (groupTargetsValid === 1'b1)
        begin
          seen = 1'b1;
          got = groupTargets;
        end
        else
        begin
          @(posedge core_clk);
          #1;
        end
      end
      `CHK(seen, (k < 7))
      `CHK(got, tgt[k])
    end
  endtask : testGroups

  task automatic setFlag(input int i, input logic v);
    case (i)
      0: overtempWarning = v;
      1: resistorDecodeError = v;
      2: pumpNotReady = v;
      3: lampShortFault = {11'h000, v};
      4: lampOpenFault = {11'h000, v};
      default: serialError = v;
    endcase
  endtask : setFlag

  task automatic testMasks();
    int pos;
    for (int i = 0; i < 6; i++)
    begin
      pos = (i < 5) ? i : POS_SERIAL_MASK;
      setFlag(i, 1'b1);
      waitOut(1'b0, 12'h001);
      `CHK(faultOutputOeN, 1'b0)
      host_u.writeReg(OFS_FAULT_MASK, 13'h0001 << pos);
      waitOut(1'b0, 12'h000);
      `CHK(faultOutputIn, 1'b1)
      host_u.writeReg(OFS_FAULT_MASK, 13'h0000);
      waitOut(1'b0, 12'h001);
      `CHK(faultOutput, 1'b1)
      setFlag(i, 1'b0);
      waitOut(1'b0, 12'h000);
    end
  endtask : testMasks

  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 reset_n = 1'b1;
    testRegs();
    testOverride();
    testGroups();
    testMasks();
    summarize();
  end
endmodule : lom_config_regs_tb_top
`default_nettype wire

// ### verification/lom_host_model.sv
// Host side of the register strobes: write and read tasks for the bench.
// Assumes the one-cycle strobe register port of lom_config_regs.
`timescale 1ns/1ns
`default_nettype none
module lom_host_model
  import lom_pkg::*;
(
  input wire logic core_clk, // System clock.
  output logic regWrEn, // Write strobe.
  output logic regRdEn, // Read strobe.
  output logic [ADDR_WIDTH-1:0] regAddr, // Register offset.
  output logic [REG_WIDTH-1:0] regWrData, // Write data.
  input wire logic [REG_WIDTH-1:0] regRdData, // Read data.
  input wire logic regRdValid // Read answer pulse.
);
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 13'h0000;
  end

  // Idle address and data are inverted so a design that ignores the
  // strobes cannot pass by seeing stale values.
  task automatic writeReg(input logic [7:0] ofs, input logic [12:0] val);
    @(posedge core_clk);
    #1;
    regAddr = ofs;
    regWrData = val;
    regWrEn = 1'b1;
    @(posedge core_clk);
    #1;
    regWrEn = 1'b0;
    regAddr = ~ofs;
    regWrData = ~val;
  endtask : writeReg

  task automatic readReg(input logic [7:0] ofs, output logic [12:0] val, output logic ok);
    int n;
    @(posedge core_clk);
    #1;
    regAddr = ofs;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~ofs;
    ok = 1'b0;
    val = 13'h0000;
    for (n = 0; n < 3 && !ok; n++)
    begin
      if (regRdValid === 1'b1)
      begin
        ok = 1'b1;
        val = regRdData;
      end
      else
      begin
        @(posedge core_clk);
        #1;
      end
    end
  endtask : readReg
endmodule : lom_host_model
`default_nettype wire
